// *** sysctl_defs.svh ***
/*
  Offsets, field positions, reset values and codes of the system control
  and clock select block. Assumes inclusion by its bare name.
*/
`ifndef SYSCTL_DEFS_SVH
`define SYSCTL_DEFS_SVH

`define OFS_INT_TB_WDT       8'h00
`define OFS_HALT_SLOW_PWM    8'h04
`define OFS_CLOCK_MODE       8'h08
`define OFS_STATUS           8'h0C

`define RST_INT_TB_WDT       8'h8A
`define RST_HALT_SLOW_PWM    8'h01
`define RST_CLOCK_MODE       8'h00

`define BIT_EDGE_HI          7
`define BIT_EDGE_LO          6
`define BIT_TB_HI            5
`define BIT_TB_LO            4
`define BIT_WDT_HI           3
`define BIT_PWM2_SEL         4
`define BIT_HALT_KEEP        0
`define BIT_LOW_POWER        1
`define BIT_SPEED_SEL        0

`define EDGE_OFF             2'h0
`define EDGE_RISE            2'h1
`define EDGE_FALL            2'h2
`define EDGE_BOTH            2'h3

`define WDT_OFF_CODE         4'hA
`define TB_BASE_LOG2         4'hA
`define TB_CNT_W             13
`define HALT_SLOW_OSC_PWM_CTRL_MASK_PWM       8'h11
`define HALT_SLOW_OSC_PWM_CTRL_MASK_BASE      8'h01
`define CLKMODE_MASK         8'h03

`endif

// *** sysctl_pkg.sv ***
/*
  Types shared by the system control and clock select block.
  Assumes sysctl_defs.svh supplies the numeric constants.
*/
package sysctl_pkg;

  typedef enum logic [1:0] {FAST_XTAL, FAST_EXT_RC, FAST_INT_RC} fast_src_t;

  typedef enum logic [1:0] {INT_FAST_RC_OSC_4M, INT_FAST_RC_OSC_8M, INT_FAST_RC_OSC_12M} int_fast_rc_osc_freq_t;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_SLOW, MODE_IDLE, MODE_SLEEP}
    power_mode_t;

  // Configuration options, fixed at programming time
  typedef struct packed {
    logic       wdt_always_on;
    fast_src_t  fast_src;
    int_fast_rc_osc_freq_t int_fast_rc_osc_freq;
    logic       slow_xtal_used;
    logic       has_slow_pins;
    logic       has_pwm2;
  } config_opts_t;

  // Pin ownership: 1 means the pin is ordinary I/O, except third_pwm_pin_sel, where 1 routes the third PWM to its pin
  typedef struct packed {
    logic port_a_bit5_io;
    logic port_a_bit6_io;
    logic slow_crystal_pins_io;
    logic third_pwm_pin_sel;
  } pin_release_t;

  typedef struct packed {
    logic       fast_osc_run;
    logic       slow_osc_run;
    logic       slow_crystal_low_power;
    logic       sysclk_speed_sel;
    logic       wdt_clk_slow;
    int_fast_rc_osc_freq_t int_fast_rc_osc_freq;
  } osc_ctrl_t;

endpackage

// *** system_control_clock_select.sv ***
/*
  System control and clock select: three control registers on APB,
  external interrupt edge detect, time-base divider, watchdog enable,
  oscillator run control, pin release and power mode tracking.
  Assumes config options are static and halt_req/wake_req are single
  cycle pulses from the core; the prescale tick is one cycle per period.
*/
// Behaviour
// - edge field 00 off, 01 rising, 10 falling, 11 both edges.
// - time-base period 2^10..2^13 prescale clocks by two-bit code.
// - watchdog code 1010 disables, any other value enables.
// - always-on option forces watchdog enabled, code ignored.
// - halt keeps slow crystal running if keep bit is 1; resets to 1.
// - bit 4 of second register routes third PWM to its pin.
// - unimplemented bits of second register read zero.
// - low-power bit 0 quick-start, 1 reduced current.
// - low-power bit clears at power-on.
// - slow crystal keeps running in either low-power setting.
// - internal fast RC offers 4, 8 or 12 MHz by configuration.
// - internal fast RC frees both main oscillator pins as I/O unless the slow crystal has no dedicated pins and uses them.
// - external RC uses only port A bit 6; bit 5 stays I/O.
// - option gives dedicated slow pins to crystal or to I/O.
// - without dedicated pins, slow crystal needs internal fast RC.
// - oscillators also clock watchdog and time base.
// - speed bit 0 runs fast oscillator; 1 slow crystal, fast stopped, if the slow crystal is usable.
// - time-base counts the timer prescale clock.
// - halt gives Idle if slow crystal runs, else Sleep.
`timescale 1ns/1ps
`include "sysctl_defs.svh"

module system_control_clock_select
  import sysctl_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire config_opts_t cfg,
  input  wire logic         ext_int_pin,
  input  wire logic         timer_prescale_clock,
  input  wire logic         halt_req,
  input  wire logic         wake_req,
  output logic              ext_int_event,
  output logic              timebase_tick,
  output logic              watchdog_enable,
  output osc_ctrl_t         osc,
  output pin_release_t      pins,
  output power_mode_t       power_mode
);

  logic [7:0]           interrupt_timebase_watchdog_ctrl_q;
  logic [7:0]           halt_slow_osc_pwm_ctrl_q;
  logic [7:0]           clkmode_q;
  logic [31:0]          prdata_q;
  logic                 pready_q;
  logic                 pslverr_q;
  logic                 ext_prev_q;
  logic                 ext_event_q;
  logic [`TB_CNT_W-1:0] tb_cnt_q;
  logic                 tb_tick_q;
  logic                 wdt_en_q;
  osc_ctrl_t            osc_q;
  osc_ctrl_t            osc_d;
  pin_release_t         pins_q;
  pin_release_t         pins_d;
  power_mode_t          mode_q;
  power_mode_t          mode_d;
  logic                 access;
  logic                 wr_en;
  logic                 slow_ok;
  logic                 slow_halt_run;
  logic [7:0]           halt_slow_osc_pwm_ctrl_mask;

  function automatic logic wdt_on(input logic force_on, input logic [3:0] c);
    wdt_on = force_on | (c != `WDT_OFF_CODE);
  endfunction

  function automatic logic [`TB_CNT_W-1:0] tb_last(input logic [1:0] sel);
    logic [3:0] sh;
    sh = `TB_BASE_LOG2 + {2'h0, sel};
    tb_last = `TB_CNT_W'((14'h0001 << sh) - 14'h0001);
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                    input logic now);
    edge_hit = ((sel == `EDGE_RISE) & ~prev & now) |
               ((sel == `EDGE_FALL) & prev & ~now) |
               ((sel == `EDGE_BOTH) & (prev ^ now));
  endfunction

  assign access = psel & penable & ~pready_q;
  assign wr_en  = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign halt_slow_osc_pwm_ctrl_mask = cfg.has_pwm2 ? `HALT_SLOW_OSC_PWM_CTRL_MASK_PWM : `HALT_SLOW_OSC_PWM_CTRL_MASK_BASE;

  // Slow crystal exists only where its pins allow it
  assign slow_ok = cfg.slow_xtal_used &
                   (cfg.has_slow_pins | (cfg.fast_src == FAST_INT_RC));
  // Shared-pin variants ignore the keep bit: the crystal always runs
  assign slow_halt_run = slow_ok &
    (~cfg.has_slow_pins | halt_slow_osc_pwm_ctrl_q[`BIT_HALT_KEEP]);

  // APB: one wait state, answer registered so outputs come from flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= access;
      pslverr_q <= 1'b0;
      if (access) begin
        if (paddr == `OFS_INT_TB_WDT) begin
          prdata_q <= {24'h00_0000, interrupt_timebase_watchdog_ctrl_q};
        end else if (paddr == `OFS_HALT_SLOW_PWM) begin
          prdata_q <= {24'h00_0000, halt_slow_osc_pwm_ctrl_q & halt_slow_osc_pwm_ctrl_mask};
        end else if (paddr == `OFS_CLOCK_MODE) begin
          prdata_q <= {24'h00_0000, clkmode_q};
        end else if (paddr == `OFS_STATUS) begin
          prdata_q <= {24'h00_0000, mode_q, osc_q.fast_osc_run,
                       osc_q.slow_osc_run, wdt_en_q, slow_ok, 2'h0};
        end else begin
          prdata_q  <= 32'h0000_0000;
          pslverr_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      interrupt_timebase_watchdog_ctrl_q <= `RST_INT_TB_WDT;
    end else if (wr_en && paddr == `OFS_INT_TB_WDT) begin
      interrupt_timebase_watchdog_ctrl_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      halt_slow_osc_pwm_ctrl_q <= `RST_HALT_SLOW_PWM;
    end else if (wr_en && paddr == `OFS_HALT_SLOW_PWM) begin
      halt_slow_osc_pwm_ctrl_q <= pwdata[7:0] & halt_slow_osc_pwm_ctrl_mask;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clkmode_q <= `RST_CLOCK_MODE;
    end else if (wr_en && paddr == `OFS_CLOCK_MODE) begin
      clkmode_q <= pwdata[7:0] & `CLKMODE_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_prev_q  <= 1'b0;
      ext_event_q <= 1'b0;
    end else begin
      ext_prev_q  <= ext_int_pin;
      ext_event_q <= edge_hit(interrupt_timebase_watchdog_ctrl_q[`BIT_EDGE_HI:`BIT_EDGE_LO],
                              ext_prev_q, ext_int_pin);
    end
  end

  // Counter keeps counting across a period change; if already at or past the new end it wraps on the next prescale tick
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tb_cnt_q  <= '0;
      tb_tick_q <= 1'b0;
    end else begin
      tb_tick_q <= 1'b0;
      if (timer_prescale_clock) begin
        if (tb_cnt_q >= tb_last(interrupt_timebase_watchdog_ctrl_q[`BIT_TB_HI:`BIT_TB_LO])) begin
          tb_cnt_q  <= '0;
          tb_tick_q <= 1'b1;
        end else begin
          tb_cnt_q <= tb_cnt_q + `TB_CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wdt_en_q <= 1'b1;
    end else begin
      wdt_en_q <= wdt_on(cfg.wdt_always_on,
                         interrupt_timebase_watchdog_ctrl_q[`BIT_WDT_HI:0]);
    end
  end

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      MODE_NORMAL, MODE_SLOW: begin
        if (halt_req) begin
          mode_d = slow_halt_run ? MODE_IDLE : MODE_SLEEP;
        end else if (slow_ok && clkmode_q[`BIT_SPEED_SEL]) begin
          mode_d = MODE_SLOW;
        end else begin
          mode_d = MODE_NORMAL;
        end
      end
      default: begin
        if (wake_req) begin
          mode_d = (slow_ok && clkmode_q[`BIT_SPEED_SEL]) ? MODE_SLOW
                                                         : MODE_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q <= MODE_NORMAL;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_comb begin
    osc_d.fast_osc_run = (mode_d == MODE_NORMAL);
    // Low-power only trims current; it never stops the crystal
    osc_d.slow_osc_run = slow_ok &
      ((mode_d != MODE_SLEEP) & (mode_d != MODE_IDLE) |
       (mode_d == MODE_IDLE));
    osc_d.slow_crystal_low_power = clkmode_q[`BIT_LOW_POWER];
    osc_d.sysclk_speed_sel = (mode_d == MODE_SLOW);
    osc_d.wdt_clk_slow = slow_ok;
    osc_d.int_fast_rc_osc_freq = cfg.int_fast_rc_osc_freq;
    pins_d.port_a_bit5_io = (cfg.fast_src != FAST_XTAL) &
      ~(slow_ok & ~cfg.has_slow_pins);
    pins_d.port_a_bit6_io = (cfg.fast_src == FAST_INT_RC) &
      ~(slow_ok & ~cfg.has_slow_pins);
    pins_d.slow_crystal_pins_io = cfg.has_slow_pins &
      ~cfg.slow_xtal_used;
    pins_d.third_pwm_pin_sel = cfg.has_pwm2 &
      halt_slow_osc_pwm_ctrl_q[`BIT_PWM2_SEL];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      osc_q  <= '0;
      pins_q <= '0;
    end else begin
      osc_q  <= osc_d;
      pins_q <= pins_d;
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign ext_int_event   = ext_event_q;
  assign timebase_tick   = tb_tick_q;
  assign watchdog_enable = wdt_en_q;
  assign osc             = osc_q;
  assign pins            = pins_q;
  assign power_mode      = mode_q;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_edge_rise;
    (interrupt_timebase_watchdog_ctrl_q[`BIT_EDGE_HI:`BIT_EDGE_LO] == `EDGE_RISE) && !ext_prev_q &&
      ext_int_pin
      |=> ext_int_event;
  endproperty
  a_edge_rise: assert property (p_edge_rise)
    else $error("rising edge not reported");

  property p_edge_off;
    $past(interrupt_timebase_watchdog_ctrl_q[`BIT_EDGE_HI:`BIT_EDGE_LO]) == `EDGE_OFF |-> !ext_int_event;
  endproperty
  a_edge_off: assert property (p_edge_off)
    else $error("edge event while interrupt disabled");

  property p_tb_period;
    timebase_tick |-> tb_cnt_q == '0 && $past(timer_prescale_clock);
  endproperty
  a_tb_period: assert property (p_tb_period)
    else $error("time-base tick without counter wrap");

  property p_wdt_code;
    !cfg.wdt_always_on && interrupt_timebase_watchdog_ctrl_q[`BIT_WDT_HI:0] == `WDT_OFF_CODE
      && $stable(interrupt_timebase_watchdog_ctrl_q) |=> !watchdog_enable;
  endproperty
  a_wdt_code: assert property (p_wdt_code)
    else $error("watchdog not disabled by off code");

  property p_wdt_force;
    cfg.wdt_always_on |=> watchdog_enable;
  endproperty
  a_wdt_force: assert property (p_wdt_force)
    else $error("watchdog off despite always-on option");

  property p_halt_mode;
    (mode_q == MODE_NORMAL || mode_q == MODE_SLOW) && halt_req
      |=> power_mode == ($past(slow_halt_run) ? MODE_IDLE : MODE_SLEEP);
  endproperty
  a_halt_mode: assert property (p_halt_mode)
    else $error("halt entered wrong low power mode");

  property p_halt_slow_osc_pwm_ctrl_zero;
    pready && !pslverr && $past(paddr) == `OFS_HALT_SLOW_PWM
      |-> (prdata[31:8] == 24'h00_0000) &&
          ((prdata[7:0] & ~(cfg.has_pwm2 ? `HALT_SLOW_OSC_PWM_CTRL_MASK_PWM
                                         : `HALT_SLOW_OSC_PWM_CTRL_MASK_BASE)) == 8'h00);
  endproperty
  a_halt_slow_osc_pwm_ctrl_zero: assert property (p_halt_slow_osc_pwm_ctrl_zero)
    else $error("unimplemented bits read nonzero");

  property p_slow_fast;
    power_mode == MODE_SLOW |-> !osc.fast_osc_run && osc.sysclk_speed_sel;
  endproperty
  a_slow_fast: assert property (p_slow_fast)
    else $error("fast oscillator running in slow mode");

  property p_idle_slow;
    power_mode == MODE_IDLE |-> osc.slow_osc_run;
  endproperty
  a_idle_slow: assert property (p_idle_slow)
    else $error("slow crystal stopped in idle");

  property p_pins_int_fast_rc_osc;
    cfg.fast_src == FAST_INT_RC && !slow_ok ##1 $stable(cfg)
      |=> pins.port_a_bit5_io && pins.port_a_bit6_io;
  endproperty
  a_pins_int_fast_rc_osc: assert property (p_pins_int_fast_rc_osc)
    else $error("main oscillator pins not released");

  property p_answer;
    psel && penable && !pready |=> pready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer late");

  c_idle: cover property (halt_req ##1 power_mode == MODE_IDLE);
  c_sleep: cover property (halt_req ##1 power_mode == MODE_SLEEP);
  c_tick: cover property (timebase_tick);
  c_both: cover property (interrupt_timebase_watchdog_ctrl_q[`BIT_EDGE_HI:`BIT_EDGE_LO] == `EDGE_BOTH
                          && ext_int_event);

endmodule

// *** prescale_source.sv ***
/*
  Timer prescale clock source standing outside the block.
  Assumes the bench sets the gap; a tick lasts one ref_clk cycle.
*/
`timescale 1ns/1ps

module prescale_source (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [1:0] gap,
  output logic            tick
);
  logic [1:0] cnt_q;

  // A slow source stretches the time base without changing its count
  always_ff @(posedge ref_clk) begin
    if (rst || cnt_q >= gap) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  assign tick = !rst && (cnt_q == gap);
endmodule

// *** system_control_clock_select_test.sv ***
/*
  Self-checking bench for the system control and clock select block.
  Assumes the design answers APB with one wait state, as handed over.
*/
`timescale 1ns/1ps
`include "sysctl_defs.svh"
`define CHK(nm, exp, got) begin total_checks++; \
  if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end

module system_control_clock_select_test;
  import sysctl_pkg::*;
  logic         ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rdv;
  logic         errv, ext_int_pin, halt_req, wake_req, tick;
  logic         ext_int_event, timebase_tick, watchdog_enable;
  logic [1:0]   gap;
  logic [2:0]   cnt;
  logic [15:0]  pc;
  logic [3:0]   code;
  config_opts_t cfg, c;
  config_opts_t cfgs [5];
  osc_ctrl_t    osc;
  pin_release_t pins;
  power_mode_t  power_mode;
  int           error_cnt, total_checks, n;

  system_control_clock_select DUT (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg(cfg), .ext_int_pin(ext_int_pin),
    .timer_prescale_clock(tick), .halt_req(halt_req),
    .wake_req(wake_req), .ext_int_event(ext_int_event),
    .timebase_tick(timebase_tick), .watchdog_enable(watchdog_enable),
    .osc(osc), .pins(pins), .power_mode(power_mode));

  prescale_source src (.ref_clk(ref_clk), .rst(rst), .gap(gap),
    .tick(tick));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  function automatic logic usable(config_opts_t k);
    return k.slow_xtal_used & (k.has_slow_pins | k.fast_src == FAST_INT_RC);
  endfunction

  function automatic pin_release_t exp_pins(config_opts_t k, logic pwm);
    logic sh;
    sh = usable(k) & ~k.has_slow_pins;
    return '{port_a_bit5_io: k.fast_src != FAST_XTAL && !sh,
      port_a_bit6_io: k.fast_src == FAST_INT_RC && !sh,
      slow_crystal_pins_io: k.has_slow_pins & ~k.slow_xtal_used,
      third_pwm_pin_sel: pwm & k.has_pwm2};
  endfunction

  function automatic power_mode_t halt_mode(config_opts_t k, logic keep);
    return (usable(k) && (keep || !k.has_slow_pins)) ? MODE_IDLE
                                                     : MODE_SLEEP;
  endfunction

  // Status after reset: normal mode, fast running, code 1010 in place
  function automatic logic [31:0] exp_status(config_opts_t k);
    return {26'h0, 1'b1, usable(k), k.wdt_always_on, usable(k), 2'h0};
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only pready, or else the watchdog process, may end this wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic pulse(input logic h);
    @(posedge ref_clk);
    halt_req <= h;
    wake_req <= !h;
    @(posedge ref_clk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
    wait_cyc(1);
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge ref_clk);
    error_cnt++;
    finish_test;
  end

  initial begin
    {rst, psel, penable, pwrite, ext_int_pin, halt_req, wake_req} = 7'h40;
    paddr = 8'h00;
    pwdata = 32'h0;
    gap = 2'h0;
    error_cnt = 0;
    total_checks = 0;
    cfgs[0] = '{1'b0, FAST_INT_RC, INT_FAST_RC_OSC_4M, 1'b1, 1'b1, 1'b1};
    cfgs[1] = '{1'b1, FAST_EXT_RC, INT_FAST_RC_OSC_4M, 1'b0, 1'b1, 1'b0};
    cfgs[2] = '{1'b0, FAST_XTAL, INT_FAST_RC_OSC_4M, 1'b1, 1'b0, 1'b1};
    cfgs[3] = '{1'b0, FAST_INT_RC, INT_FAST_RC_OSC_4M, 1'b1, 1'b0, 1'b0};
    cfgs[4] = '{1'b0, FAST_INT_RC, INT_FAST_RC_OSC_4M, 1'b0, 1'b0, 1'b1};
    cfg = cfgs[0];
    void'($urandom(10494));
    foreach (cfgs[i]) begin
      c = cfgs[i];
      c.int_fast_rc_osc_freq = int_fast_rc_osc_freq_t'($urandom_range(2, 0));
      @(posedge ref_clk);
      rst <= 1'b1;
      cfg <= c;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      wait_cyc(2);
      apb(1'b0, `OFS_INT_TB_WDT, 8'h00);
      `CHK("interrupt_timebase_watchdog_ctrl rst", 32'h8A, rdv);
      apb(1'b0, `OFS_HALT_SLOW_PWM, 8'h00);
      `CHK("halt_slow_osc_pwm_ctrl rst", 32'h01, rdv);
      apb(1'b0, `OFS_CLOCK_MODE, 8'h00);
      `CHK("clkmode rst", 32'h00, rdv);
      apb(1'b0, `OFS_STATUS, 8'h00);
      `CHK("status", exp_status(c), rdv);
      `CHK("wdt rst", c.wdt_always_on, watchdog_enable);
      apb(1'b1, 8'h10, 8'hFF);
      apb(1'b0, 8'h10, 8'h00);
      `CHK("unmapped err", 1'b1, errv);
      `CHK("unmapped data", 32'h0, rdv);
      `CHK("pins", exp_pins(c, 1'b0), pins);
      `CHK("int_fast_rc_osc", c.int_fast_rc_osc_freq, osc.int_fast_rc_osc_freq);
      `CHK("wdt clk", usable(c), osc.wdt_clk_slow);
      `CHK("low power", 1'b0, osc.slow_crystal_low_power);
      for (int k = 0; k < 6; k++) begin
        code = (k == 0) ? 4'hA : (k == 1) ? 4'h5 : 4'($urandom);
        apb(1'b1, `OFS_INT_TB_WDT, {4'h8, code});
        wait_cyc(2);
        `CHK("wdt", c.wdt_always_on|code!=4'hA, watchdog_enable);
      end
      apb(1'b1, `OFS_HALT_SLOW_PWM, 8'hFF);
      apb(1'b0, `OFS_HALT_SLOW_PWM, 8'h00);
      `CHK("halt_slow_osc_pwm_ctrl", c.has_pwm2 ? 32'h11 : 32'h01, rdv);
      `CHK("pwm pin", exp_pins(c, 1'b1), pins);
      pulse(1'b1);
      `CHK("halt keep", halt_mode(c, 1'b1), power_mode);
      `CHK("slow run", usable(c), osc.slow_osc_run);
      pulse(1'b0);
      `CHK("wake", MODE_NORMAL, power_mode);
      apb(1'b1, `OFS_HALT_SLOW_PWM, 8'h00);
      pulse(1'b1);
      `CHK("halt off", halt_mode(c, 1'b0), power_mode);
      pulse(1'b0);
      apb(1'b1, `OFS_HALT_SLOW_PWM, 8'h01);
      // Software raises low power only once the crystal has settled
      apb(1'b1, `OFS_CLOCK_MODE, 8'h02);
      wait_cyc(2);
      `CHK("lp set", 1'b1, osc.slow_crystal_low_power);
      `CHK("lp run", usable(c), osc.slow_osc_run);
      apb(1'b1, `OFS_CLOCK_MODE, 8'h03);
      wait_cyc(2);
      `CHK("slow mode", power_mode_t'(usable(c)), power_mode);
      `CHK("fast run", !usable(c), osc.fast_osc_run);
      pulse(1'b1);
      `CHK("halt slow", halt_mode(c, 1'b1), power_mode);
      pulse(1'b0);
      `CHK("wake slow", power_mode_t'(usable(c)), power_mode);
      apb(1'b1, `OFS_CLOCK_MODE, 8'h00);
      $display("config %0d done", i);
    end
    for (int e = 0; e < 4; e++) begin
      apb(1'b1, `OFS_INT_TB_WDT, {e[1:0], 6'h05});
      for (int lv = 1; lv >= 0; lv--) begin
        @(posedge ref_clk);
        ext_int_pin <= lv[0];
        cnt = 3'h0;
        repeat (4) begin
          @(posedge ref_clk);
          cnt = cnt + 3'(ext_int_event);
        end
        `CHK("edge", {2'h0, lv ? e[0] : e[1]}, cnt);
      end
    end
    $display("edge test done");
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk);
      gap <= (s == 0) ? 2'($urandom_range(2, 0)) : 2'h0;
      apb(1'b1, `OFS_INT_TB_WDT, {2'h0, s[1:0], 4'h5});
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (timebase_tick !== 1'b1 && n < 30000);
      pc = 16'(tick);
      n = 0;
      forever begin
        @(posedge ref_clk);
        n++;
        if (timebase_tick === 1'b1 || n > 30000) break;
        pc = pc + 16'(tick);
      end
      `CHK("tb period", 16'h1 << (10 + s), pc);
    end
    $display("time base test done");
    finish_test;
  end
endmodule
